// ### design/sfrg_guard.sv
// Overview of operation
// RULE_01: Boot mode may access every register group. The code denies the segmentation group in boot mode (RULE_10).
// RULE_02: Test mode may access every register group. The code denies the segmentation group in test mode (RULE_10).
// RULE_03: Contactless mode reads firewall registers, reads and writes its own registers.
// RULE_04: Contactless mode hardware access follows the firewall low and high rights.
// RULE_05: System mode reaches segmentation, system, firewall and hardware registers.
// RULE_06: User mode hardware access follows the active segment entry rights.
// RULE_07: General CPU registers are always accessible.
// RULE_08: High status word readable in contactless and user modes.
// RULE_09: Clock select readable in contactless mode regardless of firewall.
// RULE_10: Segmentation registers denied outside system mode.
// RULE_11: Protected system registers 0, 1, 2 never readable.
// RULE_12: Random number register is read-only; writes ignored.
// RULE_13: Both cipher key registers are never readable.
// RULE_14: Segment table address resets to zero, disabling all segments.
// RULE_15: Memory partition is fixed; no configuration exists.
// RULE_16: Calling system or config vector changes mode.
// RULE_17: Taking an exception or interrupt changes mode.
// RULE_18: Interrupt return restores the previous mode.
// RULE_19: Long, absolute or extended call to special address changes mode.
// RULE_20: Permitted writes to status word mode bits change mode.
// RULE_21: Denied read returns zero; denied write is discarded.
// RULE_22: Decision in the access cycle, no wait states added.
//
// Purpose: Mode-based guard on core accesses to function registers
// Assumes: APB for the guard's own settings; core answer is registered, one cycle after the access
// Notes: Segment table rights are supplied by the fetch logic
`timescale 1ns/1ps
`include "sfrg_regs.svh"
module sfrg_guard import sfrg_pkg::*; #(
  parameter logic [15:0] SYS_VECTOR = 16'h0100,
  parameter logic [15:0] CFG_VECTOR = 16'h0200
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire sfrg_acc_s CORE_ACC,
  input wire logic [2:0] CORE_GRP,
  input wire logic [7:0] SFR_RDATA,
  input wire logic [7:0] SEG_RIGHTS,
  input wire logic CALL_VALID,
  input wire logic [15:0] CALL_TARGET,
  input wire logic EXC_TAKE,
  input wire logic RETI_DONE,
  output sfrg_ans_s CORE_ANS,
  output logic SFR_WE,
  output logic [4:0] CPU_MODE,
  output logic [15:0] SEG_TABLE_ADDR
);
  logic [4:0] mode_ff;
  logic [4:0] nxt_mode;
  logic [4:0] saved_mode_ff;
  logic [7:0] fw_low_ff;
  logic [7:0] fw_high_ff;
  logic [15:0] seg_base_ff;
  logic [15:0] deny_cnt_ff;
  logic allow;
  logic [7:0] fw_sel;
  logic apb_wr;
  logic apb_rd;
  logic core_wr_ok;
  logic psw_mode_wr;
  logic [31:0] rd_mux;
  logic hit;
  sfrg_ans_s ans_ff;
  logic we_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Low byte rights cover subgroups 0-1, high byte subgroups 2-3
  assign fw_sel = CORE_ACC.addr[1] ? fw_high_ff : fw_low_ff; // RULE_04

  sfrg_decide u_decide (
    .mode(mode_ff),
    .grp(CORE_GRP),
    .addr(CORE_ACC.addr),
    .write(CORE_ACC.write),
    .fw_rights(fw_sel),
    .seg_rights(SEG_RIGHTS),
    .allow(allow)
  );

  assign core_wr_ok = CORE_ACC.valid && CORE_ACC.write && allow;
  assign psw_mode_wr = core_wr_ok && CORE_ACC.addr == `SFRG_SFR_PSW_HIGH;

  // Answer registered so outputs come from flops; one-cycle latency, no stall
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ans_ff <= '0;
      we_ff <= 1'b0;
    end else begin
      ans_ff.granted <= CORE_ACC.valid && allow; // RULE_22
      ans_ff.rdata <= (CORE_ACC.valid && !CORE_ACC.write && allow) ?
                      SFR_RDATA : 8'h00; // RULE_21
      we_ff <= core_wr_ok; // RULE_21
    end
  end

  // Mode sequencing: return beats entry beats calls beats status writes
  always_comb begin
    nxt_mode = mode_ff;
    if (psw_mode_wr) begin
      case (CORE_ACC.wdata[`SFRG_SW_MODE_LSB +: 2])
        2'h0: nxt_mode = `SFRG_MODE_SYS; // RULE_20
        2'h1: nxt_mode = `SFRG_MODE_USER; // RULE_20
        2'h2: nxt_mode = `SFRG_MODE_CLOS; // RULE_20
        default: nxt_mode = mode_ff;
      endcase
    end
    if (CALL_VALID && CALL_TARGET == SYS_VECTOR) nxt_mode = `SFRG_MODE_SYS; // RULE_16 RULE_19
    if (CALL_VALID && CALL_TARGET == CFG_VECTOR) nxt_mode = `SFRG_MODE_SYS; // RULE_16 RULE_19
    if (EXC_TAKE) nxt_mode = `SFRG_MODE_SYS; // RULE_17
    if (RETI_DONE) nxt_mode = saved_mode_ff; // RULE_18
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_ff <= `SFRG_MODE_BOOT;
      saved_mode_ff <= `SFRG_MODE_BOOT;
    end else begin
      mode_ff <= nxt_mode;
      if (EXC_TAKE && !RETI_DONE) saved_mode_ff <= mode_ff; // RULE_17
    end
  end

  // APB side: setting writes only from a mode that may write them
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && !PENABLE && !PWRITE;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `SFRG_CFG_OFF: rd_mux = {27'h0, mode_ff};
      `SFRG_FW_LOW_OFF: rd_mux = {24'h0, fw_low_ff};
      `SFRG_FW_HIGH_OFF: rd_mux = {24'h0, fw_high_ff};
      `SFRG_SEG_BASE_OFF: rd_mux = {16'h0, seg_base_ff};
      `SFRG_SEG_RIGHTS_OFF: rd_mux = {24'h0, SEG_RIGHTS};
      `SFRG_STATUS_OFF: rd_mux = {27'h0, saved_mode_ff};
      `SFRG_DENY_CNT_OFF: rd_mux = {16'h0, deny_cnt_ff};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fw_low_ff <= `SFRG_FW_RST;
      fw_high_ff <= `SFRG_FW_RST;
      seg_base_ff <= `SFRG_SEG_BASE_RST; // RULE_14
    end else if (apb_wr) begin
      // Firewall settings only writable from system, boot or test
      if (PADDR == `SFRG_FW_LOW_OFF && mode_ff != `SFRG_MODE_CLOS &&
          mode_ff != `SFRG_MODE_USER) fw_low_ff <= PWDATA[7:0];
      if (PADDR == `SFRG_FW_HIGH_OFF && mode_ff != `SFRG_MODE_CLOS &&
          mode_ff != `SFRG_MODE_USER) fw_high_ff <= PWDATA[7:0];
      if (PADDR == `SFRG_SEG_BASE_OFF && mode_ff == `SFRG_MODE_SYS)
        seg_base_ff <= PWDATA[15:0]; // RULE_10
    end
  end

  // Denial count is diagnostic; saturates instead of wrapping
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      deny_cnt_ff <= 16'h0000;
    end else if (CORE_ACC.valid && !allow && deny_cnt_ff != 16'hffff) begin
      deny_cnt_ff <= deny_cnt_ff + 16'h0001;
    end
  end

  // Zero-wait slave: PREADY high in every access phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= PSEL && !PENABLE;
      pslverr_ff <= PSEL && !PENABLE && !hit;
      if (apb_rd) prdata_ff <= rd_mux;
    end
  end

  // No partition register exists: the split is fixed in hardware. RULE_15
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign CORE_ANS = ans_ff;
  assign SFR_WE = we_ff;
  assign CPU_MODE = mode_ff;
  assign SEG_TABLE_ADDR = seg_base_ff;
endmodule

// ### design/sfrg_regs.svh
// Purpose: Offsets, fields, reset values and codes for the register guard
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SFRG_REGS_SVH
`define SFRG_REGS_SVH
`define SFRG_CFG_OFF 12'h000
`define SFRG_FW_LOW_OFF 12'h004
`define SFRG_FW_HIGH_OFF 12'h008
`define SFRG_SEG_BASE_OFF 12'h00c
`define SFRG_SEG_RIGHTS_OFF 12'h010
`define SFRG_STATUS_OFF 12'h014
`define SFRG_DENY_CNT_OFF 12'h018
`define SFRG_SEG_BASE_RST 16'h0000
`define SFRG_FW_RST 8'h00
`define SFRG_RIGHTS_RST 8'h00
`define SFRG_MODE_BOOT 5'h01
`define SFRG_MODE_TEST 5'h02
`define SFRG_MODE_CLOS 5'h04
`define SFRG_MODE_SYS 5'h08
`define SFRG_MODE_USER 5'h10
`define SFRG_SW_MODE_LSB 0
`define SFRG_GRP_CPU 3'h0
`define SFRG_GRP_SEG 3'h1
`define SFRG_GRP_SYS 3'h2
`define SFRG_GRP_FW 3'h3
`define SFRG_GRP_CLOS 3'h4
`define SFRG_GRP_HW 3'h5
`define SFRG_SFR_PSW_HIGH 8'hd0
`define SFRG_SFR_PROT0 8'ha0
`define SFRG_SFR_PROT1 8'ha1
`define SFRG_SFR_PROT2 8'ha2
`define SFRG_SFR_RNG 8'hb0
`define SFRG_SFR_PKKEY 8'hb1
`define SFRG_SFR_SCKEY 8'hb2
`define SFRG_SFR_CLOCK_SELECT 8'hb3
`endif

// ### design/sfrg_pkg.sv
// Purpose: Types shared by the register guard
// Assumes: Nothing
// Notes: Constants live in sfrg_regs.svh
package sfrg_pkg;
  typedef enum logic [4:0] {
    SFRG_BOOT = 5'b00001,
    SFRG_TEST = 5'b00010,
    SFRG_CLOS = 5'b00100,
    SFRG_SYS = 5'b01000,
    SFRG_USER = 5'b10000
  } sfrg_mode_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrg_acc_s;
  typedef struct packed {
    logic [7:0] rdata;
    logic granted;
  } sfrg_ans_s;
endpackage

// ### design/sfrg_decide.sv
// Purpose: Combinational grant decision for one register access
// Assumes: Group code of the address supplied by the caller
// Notes: No state, so decisions add no wait state
`timescale 1ns/1ps
`include "sfrg_regs.svh"
module sfrg_decide import sfrg_pkg::*; (
  input wire logic [4:0] mode,
  input wire logic [2:0] grp,
  input wire logic [7:0] addr,
  input wire logic write,
  input wire logic [7:0] fw_rights,
  input wire logic [7:0] seg_rights,
  output logic allow
);
  logic base;
  logic fw_ok;
  logic seg_ok;
  always_comb begin
    // Rights: bit 2*g read, bit 2*g+1 write for hardware subgroup g
    fw_ok = fw_rights[{addr[1:0], write}];
    seg_ok = seg_rights[{addr[1:0], write}];
    base = 1'b0;
    case (mode)
      `SFRG_MODE_BOOT: base = 1'b1; // RULE_01
      `SFRG_MODE_TEST: base = 1'b1; // RULE_02
      `SFRG_MODE_CLOS: begin
        if (grp == `SFRG_GRP_FW) base = !write; // RULE_03
        else if (grp == `SFRG_GRP_CLOS) base = 1'b1; // RULE_03
        else if (grp == `SFRG_GRP_HW) base = fw_ok; // RULE_04
        if (addr == `SFRG_SFR_CLOCK_SELECT && !write) base = 1'b1; // RULE_09
      end
      `SFRG_MODE_SYS: base = grp != `SFRG_GRP_CLOS; // RULE_05
      `SFRG_MODE_USER: begin
        if (grp == `SFRG_GRP_HW) base = seg_ok; // RULE_06
      end
      default: base = 1'b0;
    endcase
    if (grp == `SFRG_GRP_CPU) base = 1'b1; // RULE_07
    if (addr == `SFRG_SFR_PSW_HIGH && !write &&
        (mode == `SFRG_MODE_CLOS || mode == `SFRG_MODE_USER)) base = 1'b1; // RULE_08
    if (grp == `SFRG_GRP_SEG && mode != `SFRG_MODE_SYS) base = 1'b0; // RULE_10
    if (!write && (addr == `SFRG_SFR_PROT0 || addr == `SFRG_SFR_PROT1 ||
        addr == `SFRG_SFR_PROT2)) base = 1'b0; // RULE_11
    if (write && addr == `SFRG_SFR_RNG) base = 1'b0; // RULE_12
    if (!write && (addr == `SFRG_SFR_PKKEY || addr == `SFRG_SFR_SCKEY)) base = 1'b0; // RULE_13
    allow = base;
  end
endmodule

// ### test/sfrg_guard_properties.sv
// Purpose: Concurrent checks on the guard's core and mode ports
// Assumes: Bound to sfrg_guard
// Notes: Fixed denials are excluded from the open-mode checks
`timescale 1ns/1ps
`include "sfrg_regs.svh"
module sfrg_guard_properties import sfrg_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire sfrg_acc_s CORE_ACC,
  input wire logic [2:0] CORE_GRP,
  input wire logic [7:0] SFR_RDATA,
  input wire logic EXC_TAKE,
  input wire logic RETI_DONE,
  input wire sfrg_ans_s CORE_ANS,
  input wire logic SFR_WE,
  input wire logic [4:0] CPU_MODE,
  input wire logic [15:0] SEG_TABLE_ADDR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic [7:0] a = CORE_ACC.addr;
  wire logic rd = CORE_ACC.valid && !CORE_ACC.write;
  wire logic wr = CORE_ACC.valid && CORE_ACC.write;
  wire logic key = a == `SFRG_SFR_PKKEY || a == `SFRG_SFR_SCKEY;
  wire logic prot = a inside {`SFRG_SFR_PROT0, `SFRG_SFR_PROT1, `SFRG_SFR_PROT2};
  // Hardwired denials override every mode grant
  wire logic fixed = (rd && (key || prot)) || (wr && a == `SFRG_SFR_RNG);
  chk_prot_hidden: assert property (rd && prot |=> CORE_ANS == '0)
    else $error("protected register read not hidden");
  chk_key_hidden: assert property (rd && key |=> CORE_ANS == '0)
    else $error("key register read not hidden");
  chk_rng_ro: assert property (wr && a == `SFRG_SFR_RNG |=> !SFR_WE)
    else $error("random register write took effect");
  // Segmentation group stays shut outside system mode, even in boot and test
  chk_boot_open: assert property (CORE_ACC.valid && CPU_MODE == SFRG_BOOT && !fixed
    && CORE_GRP != 3'h1 |=> CORE_ANS.granted) else $error("boot access denied");
  chk_test_open: assert property (CORE_ACC.valid && CPU_MODE == SFRG_TEST && !fixed
    && CORE_GRP != 3'h1 |=> CORE_ANS.granted) else $error("test access denied");
  chk_cpu_open: assert property (CORE_ACC.valid && CORE_GRP == 3'h0 && !fixed
    |=> CORE_ANS.granted) else $error("cpu register denied");
  chk_seg_closed: assert property (CORE_ACC.valid && CORE_GRP == 3'h1 &&
    CPU_MODE inside {SFRG_BOOT, SFRG_TEST, SFRG_CLOS, SFRG_USER}
    |=> !CORE_ANS.granted) else $error("seg access leaked");
  chk_sys_seg: assert property (CORE_ACC.valid && CORE_GRP == 3'h1 && !fixed &&
    CPU_MODE == SFRG_SYS |=> CORE_ANS.granted) else $error("system seg access denied");
  chk_deny_zero: assert property (rd |=> CORE_ANS.rdata ==
    (CORE_ANS.granted ? $past(SFR_RDATA) : 8'h00)) else $error("read data wrong");
  chk_we_match: assert property (wr |=> SFR_WE == CORE_ANS.granted)
    else $error("write strobe disagrees with grant");
  chk_exc_sys: assert property (EXC_TAKE && !RETI_DONE |=> CPU_MODE == SFRG_SYS)
    else $error("exception did not enter system mode");
  chk_reset_seg: assert property (disable iff (1'b0) RST |=>
    SEG_TABLE_ADDR == `SFRG_SEG_BASE_RST) else $error("segment table not cleared");
  cover property (CORE_ACC.valid && CPU_MODE == SFRG_USER);
  cover property (rd && CPU_MODE == SFRG_CLOS);
  cover property (EXC_TAKE);
endmodule

// ### test/sfrg_core_model.sv
// Purpose: Core stand-in issuing one register access at a time
// Assumes: Answer registered one cycle after the access
// Notes: Raw contents are a scramble of the address; idle data is the inverted address
`timescale 1ns/1ps
module sfrg_core_model import sfrg_pkg::*; (
  input wire logic clk,
  input wire sfrg_ans_s ans,
  input wire logic we,
  output sfrg_acc_s acc,
  output logic [2:0] grp,
  output logic [7:0] raw
);
  initial begin
    acc = '0;
    grp = '0;
  end
  assign raw = acc.valid ? acc.addr ^ 8'h5a : ~acc.addr;
  task automatic access(input logic w, input logic [7:0] a, input logic [2:0] g,
      input logic [7:0] d, output sfrg_ans_s r, output logic e);
    @(posedge clk);
    acc <= {1'b1, w, a, d};
    grp <= g;
    @(posedge clk);
    acc.valid <= 1'b0;
    #1;
    r = ans;
    e = we;
  endtask
endmodule

// ### test/sfrg_guard_tb.sv
// Purpose: Self-checking bench for the register guard
// Assumes: Test mode has no entry path, so only the checker covers it
// Notes: Firewall low byte all open, high byte all shut
`timescale 1ns/1ps
module sfrg_guard_tb import sfrg_pkg::*; ;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sfr_we;
  logic call_valid = 0, exc_take = 0, reti_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] raw, seg_rights = 8'h01;
  logic [15:0] call_target = '0, seg_addr;
  logic [4:0] cpu_mode;
  logic [2:0] grp;
  sfrg_acc_s acc;
  sfrg_ans_s ans;
  int error_cnt = 0, checks = 0;
  sfrg_guard DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CORE_ACC(acc), .CORE_GRP(grp), .SFR_RDATA(raw), .SEG_RIGHTS(seg_rights),
    .CALL_VALID(call_valid), .CALL_TARGET(call_target), .EXC_TAKE(exc_take),
    .RETI_DONE(reti_done), .CORE_ANS(ans), .SFR_WE(sfr_we), .CPU_MODE(cpu_mode),
    .SEG_TABLE_ADDR(seg_addr));
  sfrg_core_model core (.clk(clk), .ans(ans), .we(sfr_we), .acc(acc), .grp(grp), .raw(raw));
  initial forever #4 clk = ~clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [2:0] g, input logic ok);
    sfrg_ans_s r;
    logic e;
    core.access(1'b0, a, g, 8'h00, r, e);
    chk({r.granted, r.rdata}, ok ? {1'b1, a ^ 8'h5a} : 9'h000, "read");
  endtask
  task wr(input logic [7:0] a, input logic [2:0] g, input logic [7:0] d, input logic ok);
    sfrg_ans_s r;
    logic e;
    core.access(1'b1, a, g, d, r, e);
    chk({31'h0, e}, {31'h0, ok}, "write");
  endtask
  task mode(input logic [4:0] m);
    @(posedge clk);
    #1;
    chk(cpu_mode, m, "mode");
  endtask
  // Kind 0 exception, 1 return, 2 call
  task ev(input int k, input logic [15:0] t, input logic [4:0] m);
    @(posedge clk);
    exc_take <= k == 0;
    reti_done <= k == 1;
    call_valid <= k == 2;
    call_target <= t;
    @(posedge clk);
    exc_take <= 1'b0;
    reti_done <= 1'b0;
    call_valid <= 1'b0;
    mode(m);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_boot;
    logic [31:0] r;
    logic e;
    rd(8'h10, 3'h5, 1);
    rd(8'h20, 3'h1, 0);
    for (int i = 0; i < 3; i++) rd(8'ha0 + 8'(i), 3'h2, 0);
    rd(8'hb1, 3'h5, 0);
    rd(8'hb2, 3'h5, 0);
    wr(8'hb0, 3'h5, 8'h33, 0);
    wr(8'h10, 3'h5, 8'h33, 1);
    apb(1, 12'h004, 32'hff, r, e);
    apb(1, 12'h008, 32'h00, r, e);
    apb(0, 12'h004, 32'h0, r, e);
    chk(r, 32'hff, "fw low");
    // Seven core accesses above were refused
    apb(0, 12'h018, 32'h0, r, e);
    chk(r, 32'h7, "deny count");
    apb(0, 12'h0fc, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
    $display("boot done");
  endtask
  task t_clos;
    wr(8'hd0, 3'h2, 8'h02, 1);
    mode(5'h04);
    rd(8'h00, 3'h5, 1);
    rd(8'h02, 3'h5, 0);
    rd(8'hb3, 3'h5, 1);
    rd(8'hd0, 3'h2, 1);
    rd(8'h40, 3'h3, 1);
    wr(8'h40, 3'h3, 8'h00, 0);
    wr(8'h50, 3'h4, 8'h01, 1);
    rd(8'h20, 3'h1, 0);
    wr(8'h30, 3'h0, 8'h01, 1);
    $display("clos done");
  endtask
  task t_sys;
    logic [31:0] r;
    logic e;
    ev(0, 16'h0, 5'h08);
    rd(8'h20, 3'h1, 1);
    rd(8'h02, 3'h5, 1);
    apb(1, 12'h00c, 32'h1234, r, e);
    #1;
    chk(seg_addr, 32'h1234, "seg base sys");
    ev(1, 16'h0, 5'h04);
    ev(2, 16'h0300, 5'h04);
    ev(2, 16'h0100, 5'h08);
    wr(8'hd0, 3'h2, 8'h02, 1);
    ev(2, 16'h0200, 5'h08);
    wr(8'hd0, 3'h2, 8'h01, 1);
    mode(5'h10);
    $display("modes done");
  endtask
  task t_user;
    logic [31:0] r;
    logic e;
    apb(1, 12'h00c, 32'h5678, r, e);
    #1;
    chk(seg_addr, 32'h1234, "seg base user");
    rd(8'h00, 3'h5, 1);
    wr(8'h00, 3'h5, 8'h11, 0);
    rd(8'hd0, 3'h2, 1);
    rd(8'h20, 3'h1, 0);
    wr(8'hd0, 3'h2, 8'h00, 0);
    mode(5'h10);
    $display("user done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk(seg_addr, 32'h0, "seg base");
    chk(cpu_mode, 32'h01, "boot mode");
    @(posedge clk);
    rst <= 1'b0;
    t_boot;
    t_clos;
    t_sys;
    t_user;
    results;
  end
  // Suite needs under 400 cycles
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule
bind sfrg_guard sfrg_guard_properties u_props (.CORE_CLK(CORE_CLK), .RST(RST),
  .CORE_ACC(CORE_ACC), .CORE_GRP(CORE_GRP), .SFR_RDATA(SFR_RDATA), .EXC_TAKE(EXC_TAKE),
  .RETI_DONE(RETI_DONE), .CORE_ANS(CORE_ANS), .SFR_WE(SFR_WE), .CPU_MODE(CPU_MODE),
  .SEG_TABLE_ADDR(SEG_TABLE_ADDR));
